// ===== hdl/bsc_defines.svh
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// ==========================================
// register addresses on the byte-wide register port
`define BSC_ADDR_RESULT_DATA 8'h91
`define BSC_ADDR_CONTROL     8'h92
`define BSC_ADDR_BYTE_INPUT  8'h93
`define BSC_ADDR_BIT_REVERSE 8'h94
`define BSC_ADDR_AUTO_CTRL   8'h96
`define BSC_ADDR_SECTOR_CNT  8'h97

// ==========================================
// control register fields
`define BSC_CTL_SEL_BIT      0
`define BSC_CTL_INIT_BIT     2
`define BSC_CTL_FLIP_BIT     4
`define BSC_CTL_BUSY_BIT     7
`define BSC_CTL_RW_MASK      8'h11

// ==========================================
// generator, reset, timing and fifo depth values
`define BSC_POLY             16'h1021
`define BSC_INIT_VALUE       16'hffff
`define BSC_ACC_RESET        16'h0000
`define BSC_BYTE_RESET       8'h00
`define BSC_STEPS_PER_BYTE   4'h8
`define BSC_FIFO_DEPTH       32

`endif

// ===== hdl/bsc_pkg.sv
package bsc_pkg;

    // ==========================================
    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bsc_req_type;

    // ==========================================
    // register port answer
    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } bsc_rsp_type;

    typedef enum logic [0:0] {
        BSC_IDLE,
        BSC_SHIFT
    } bsc_state_type;

endpackage : bsc_pkg

// ===== hdl/bsc_engine.sv
`timescale 1ns/1ps
`include "bsc_defines.svh"
// Notes on behaviour
// - each byte is xored into the upper eight accumulator bits, lower bits kept
// - bit step: shift left, xor generator when bit 15 was one
// - exactly eight bit steps per byte before it counts processed
// - after eight steps the 16-bit remainder is the current result
// - byte bit 7 is most significant and enters the remainder first
// - one byte per input write, result updated after every byte
// - control flip bit presents the 16-bit result bit-reversed
// - generator always applied msb first regardless of reversal options

// ==========================================
// fifo of input bytes
module bsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `BSC_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } bsc_fifo_st_type;

    bsc_fifo_st_type st_q;
    bsc_fifo_st_type st_d;
    logic            push;
    logic            pop;

    // handshakes and flags
    assign o_in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (st_q.cnt != '0);
    assign o_out_data  = st_q.mem[st_q.rp];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // next state
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = i_in_data;
            st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : bsc_fifo

// ==========================================
// crc engine top
module bsc_engine (
    // clock and reset
    input  wire logic           i_core_clk,
    input  wire logic           i_resetn,
    // register port
    input  wire bsc_pkg::bsc_req_type i_req,
    output bsc_pkg::bsc_rsp_type      o_rsp,
    // status
    output logic                o_busy,
    output logic                o_in_ready
);
    import bsc_pkg::*;

    typedef struct packed {
        logic [1:0]    rst_sync;
        bsc_state_type state;
        logic [15:0]   acc;
        logic [3:0]    steps;
        logic          sel_hi;
        logic          flip;
        logic [7:0]    rev;
        logic [7:0]    auto_ctl;
        logic [7:0]    sec_cnt;
        bsc_rsp_type   rsp;
        logic          busy;
        logic          in_ready;
    } bsc_st_type;

    bsc_st_type st_q;
    bsc_st_type st_d;
    logic       rst_n;
    logic       f_ready;
    logic       f_valid;
    logic [7:0] f_data;
    logic       f_pop;
    logic       in_push;

    // reverse bit order of a byte
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int k = 0; k < 8; k++) begin
            r[k] = v[7-k];
        end
        return r;
    endfunction : rev8

    // one generator step, msb first
    function automatic logic [15:0] crc_step(input logic [15:0] a);
        logic [15:0] s;
        s = {a[14:0], 1'b0};
        return a[15] ? (s ^ `BSC_POLY) : s;
    endfunction : crc_step

    assign rst_n   = st_q.rst_sync[1];
    assign in_push = i_req.wr && (i_req.addr == `BSC_ADDR_BYTE_INPUT);
    assign f_pop   = f_valid && (st_q.state == BSC_IDLE);

    // input byte buffer
    bsc_fifo #(.WIDTH(8), .DEPTH(`BSC_FIFO_DEPTH)) u_fifo (
        .i_clk       (i_core_clk),
        .i_rst_n     (rst_n),
        .i_in_valid  (in_push),
        .o_in_ready  (f_ready),
        .i_in_data   (i_req.wdata),
        .o_out_valid (f_valid),
        .i_out_ready (f_pop),
        .o_out_data  (f_data)
    );

    // next state
    always_comb begin
        logic [15:0] res;
        res = '0;
        st_d = st_q;
        st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
        st_d.rsp.valid = 1'b0;
        res = st_q.flip ? {rev8(st_q.acc[7:0]), rev8(st_q.acc[15:8])} : st_q.acc;
        // byte engine
        unique case (st_q.state)
            BSC_IDLE: begin
                if (f_valid) begin
                    st_d.acc = st_q.acc ^ {f_data, 8'h00};
                    st_d.steps = `BSC_STEPS_PER_BYTE;
                    st_d.state = BSC_SHIFT;
                end
            end
            BSC_SHIFT: begin
                st_d.acc = crc_step(st_q.acc);
                st_d.steps = st_q.steps - 4'h1;
                if (st_q.steps == 4'h1) begin
                    st_d.state = BSC_IDLE;
                end
            end
        endcase
        // register writes
        if (i_req.wr) begin
            case (i_req.addr)
                `BSC_ADDR_RESULT_DATA: begin
                    if (st_q.sel_hi) st_d.acc[15:8] = i_req.wdata;
                    else st_d.acc[7:0] = i_req.wdata;
                end
                `BSC_ADDR_CONTROL: begin
                    st_d.sel_hi = i_req.wdata[`BSC_CTL_SEL_BIT];
                    st_d.flip = i_req.wdata[`BSC_CTL_FLIP_BIT];
                    if (i_req.wdata[`BSC_CTL_INIT_BIT]) st_d.acc = `BSC_INIT_VALUE;
                end
                `BSC_ADDR_BIT_REVERSE: st_d.rev = rev8(i_req.wdata);
                `BSC_ADDR_AUTO_CTRL:   st_d.auto_ctl = i_req.wdata;
                `BSC_ADDR_SECTOR_CNT:  st_d.sec_cnt = i_req.wdata;
                default: ;
            endcase
        end
        // register reads
        if (i_req.rd) begin
            st_d.rsp.valid = 1'b1;
            case (i_req.addr)
                `BSC_ADDR_RESULT_DATA: st_d.rsp.rdata = st_q.sel_hi ? res[15:8] : res[7:0];
                `BSC_ADDR_CONTROL: st_d.rsp.rdata = {st_q.busy, 2'b00, st_q.flip, 3'b000,
                                                     st_q.sel_hi};
                `BSC_ADDR_BIT_REVERSE: st_d.rsp.rdata = st_q.rev;
                `BSC_ADDR_AUTO_CTRL:   st_d.rsp.rdata = st_q.auto_ctl;
                `BSC_ADDR_SECTOR_CNT:  st_d.rsp.rdata = st_q.sec_cnt;
                default:               st_d.rsp.rdata = `BSC_BYTE_RESET;
            endcase
        end
        st_d.busy = (st_d.state != BSC_IDLE) || f_valid;
        st_d.in_ready = f_ready;
    end

    assign o_rsp      = st_q.rsp;
    assign o_busy     = st_q.busy;
    assign o_in_ready = st_q.in_ready;

    // state register, reset released through two flops
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= '0;
        end else if (!st_q.rst_sync[1]) begin
            st_q.rst_sync <= st_d.rst_sync;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : bsc_engine

// ===== testbench/bsc_host_monitor.sv
`timescale 1ns/1ps
// ==========================================
// port checker of the crc engine
module bsc_chk_monitor (
    input wire logic                 i_core_clk,
    input wire logic                 i_resetn,
    input wire bsc_pkg::bsc_req_type i_req,
    input wire bsc_pkg::bsc_rsp_type o_rsp,
    input wire logic                 o_busy,
    input wire logic                 o_in_ready
);
    import bsc_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // input byte write while the registered o_in_ready, the fifo ready of the cycle before, is high
    wire logic feed = i_req.wr && i_req.addr == 8'h93 && o_in_ready;
    property p_answer; i_req.rd |=> o_rsp.valid; endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_quiet; !i_req.rd |=> !o_rsp.valid; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without read");
    property p_start; feed && !o_busy |-> ##[1:3] o_busy; endproperty
    a_start: assert property (p_start) else $error("byte not started");
    property p_steps; $rose(o_busy) |-> o_busy [*8]; endproperty
    a_steps: assert property (p_steps) else $error("fewer than eight steps");
    property p_hold; !o_rsp.valid |-> $stable(o_rsp.rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_ctl; i_req.rd && i_req.addr == 8'h92 |=> (o_rsp.rdata & 8'h6e) == 8'h00; endproperty
    a_ctl: assert property (p_ctl) else $error("control spare bits set");
    property p_unmap; i_req.rd && i_req.addr == 8'h95 |=> o_rsp.rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_full; $fell(o_in_ready) |-> o_busy; endproperty
    a_full: assert property (p_full) else $error("full while idle");
    c_read: cover property (o_rsp.valid);
    c_busy: cover property ($rose(o_busy));
    c_full: cover property ($fell(o_in_ready));
endmodule : bsc_chk_monitor
bind bsc_engine bsc_chk_monitor u_mon (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_req(i_req), .o_rsp(o_rsp), .o_busy(o_busy), .o_in_ready(o_in_ready));

// ===== testbench/bsc_host_model.sv
`timescale 1ns/1ps
// ==========================================
// processor side of the register port
module bsc_host_model (
    input  wire logic            i_core_clk,
    output bsc_pkg::bsc_req_type o_req
);
    import bsc_pkg::*;
    initial o_req = '0;
    // one request a cycle, held until the next edge
    task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        o_req = {w, r, a, d};
        @(posedge i_core_clk);
        #1;
    endtask : xfer
endmodule : bsc_host_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench
module tb;
    import bsc_pkg::*;
    logic        clk;
    logic        rst_n;
    bsc_req_type req;
    bsc_rsp_type rsp;
    logic        busy;
    logic        in_ready;
    logic [7:0]  exp_q[$];
    int          errors;
    int          check_count;
    int          k;
    int          n;
    logic [15:0] lfsr;
    logic [15:0] acc;
    logic [7:0]  b;
    logic [7:0]  vb[0:10] = '{8'h63, 8'h8c, 8'h7d, 8'haa, 8'hbb, 8'hcc,
                              8'h00, 8'h00, 8'haa, 8'hbb, 8'hcc};
    int          vl[0:4] = '{1, 1, 1, 3, 5};
    logic [15:0] vr[0:4] = '{16'hbd35, 16'hb1f4, 16'h4eca, 16'h6cf6, 16'hb166};
    bsc_engine u_dut (.i_core_clk(clk), .i_resetn(rst_n), .i_req(req), .o_rsp(rsp),
        .o_busy(busy), .o_in_ready(in_ready));
    bsc_host_model u_host (.i_core_clk(clk), .o_req(req));
    // reference byte update, msb first
    function automatic logic [15:0] upd(input logic [15:0] a, input logic [7:0] d);
        a = a ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) a = a[15] ? ({a[14:0], 1'b0} ^ 16'h1021) : {a[14:0], 1'b0};
        return a;
    endfunction : upd
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd
    // reference bit reversal of a byte
    function automatic logic [7:0] flip8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = v[7-i];
        return r;
    endfunction : flip8
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task automatic wait_idle();
        int i;
        repeat (3) u_host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
        for (i = 0; i < 500 && busy !== 1'b0; i++) u_host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
        if (i == 500) begin
            errors++;
            $display("FAIL t=%0t exp=%h got=%h", $time, 1'b0, busy);
        end
    endtask : wait_idle
    task automatic read_crc(input logic f, input logic [15:0] e);
        wr(8'h92, {3'h0, f, 4'h0});
        rd(8'h91, e[7:0]);
        wr(8'h92, {3'h0, f, 4'h1});
        rd(8'h91, e[15:8]);
    endtask : read_crc
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic end_sim();
        if (exp_q.size() != 0) errors++;
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // answer watcher
    always @(negedge clk) begin
        if (rsp.valid === 1'b1) chk(exp_q.pop_front(), rsp.rdata);
    end
    // watchdog
    initial begin
        #200000;
        errors++;
        end_sim();
    end
    // main sequence
    initial begin
        rst_n = 1'b0; errors = 0; check_count = 0; lfsr = 16'h38dc; k = 0; n = 0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) u_host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
        rd(8'h91, 8'h00);
        rd(8'h95, 8'h00);
        for (int i = 0; i < 4; i++) begin
            b = rnd();
            wr(8'h94, b);
            rd(8'h94, flip8(b));
            b = rnd();
            wr(8'h96, b);
            rd(8'h96, b);
            wr(8'h97, ~b);
            rd(8'h97, ~b);
        end
        for (int v = 0; v < 5; v++) begin
            wr(8'h92, 8'h04);
            for (int j = 0; j < vl[v]; j++) begin
                wr(8'h93, vb[k]);
                k++;
            end
            u_host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
            rd(8'h92, 8'h80);
            wait_idle();
            read_crc(1'b0, vr[v]);
        end
        read_crc(1'b1, {flip8(vr[4][7:0]), flip8(vr[4][15:8])});
        acc = {rnd(), rnd()};
        wr(8'h92, 8'h00); wr(8'h91, acc[7:0]); wr(8'h92, 8'h01); wr(8'h91, acc[15:8]);
        while (in_ready === 1'b1 && n < 64) begin
            b = rnd();
            wr(8'h93, b);
            // ready after the write edge tells whether that byte was taken
            if (in_ready === 1'b1) acc = upd(acc, b);
            n++;
        end
        wait_idle();
        read_crc(1'b0, acc);
        rd(8'h92, 8'h01);
        repeat (4) u_host.xfer(1'b0, 1'b0, 8'h00, 8'h00);
        end_sim();
    end
endmodule : tb
